// *** icra_config_reg.sv ***
// ISA resource configuration register with guarded read-then-write access.
// Assumes register strobes are one-cycle pulses synchronous to clk, one access per cycle.
// The rest of the register map sits outside; its read data arrives on core_rdata.
`timescale 1ns/1ps

module icra_config_reg
  import icra_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire icra_access_s acc,
  input wire logic [1:0] page_sel,
  input wire logic [7:0] core_rdata,
  input wire logic irq_req,
  output logic [7:0] rdata,
  output logic cfg_rd_hit,
  output logic remote_byte_count_low_we,
  output logic [7:0] remote_byte_count_low,
  output logic [9:0] io_base,
  output logic [7:0] irq_lines,
  output logic fast_remote_read,
  output logic page2_sel
);

  icra_config_s cfg_q, cfg_d;
  icra_state_e state_q, state_d;
  logic [7:0] rdata_d;
  logic rd_hit_d;
  logic rbcl_we_d;
  logic [7:0] rbcl_d;
  logic [9:0] io_base_d;
  logic [7:0] irq_d;
  logic fast_d;
  logic page2_d;
  logic hit;
  logic commit;
  logic steer;

  // True only for the configuration slot: offset 0AH with page 0 selected
  function automatic logic is_cfg_slot(input logic [1:0] page, input logic [3:0] addr);
    return (page == ICRA_PAGE_0) && (addr == ICRA_OFS_CONFIG);
  endfunction

  function automatic logic [9:0] io_base_of(input logic [3:0] sel);
    logic [9:0] base;
    base = sel[3] ? ICRA_IOBASE_LO : ICRA_IOBASE_HI;
    return base + (10'(sel[2:0]) << ICRA_IOBASE_STEP_LSB);
  endfunction

  // Only the selected line can go active; bit order is IRQ3, IRQ4, IRQ5, IRQ9, IRQ10, IRQ11, IRQ12, IRQ15
  function automatic logic [7:0] irq_decode(input logic [2:0] sel, input logic req);
    logic [7:0] v;
    v = 8'h00;
    case (sel)
      3'h0: v[0] = req;
      3'h1: v[1] = req;
      3'h2: v[2] = req;
      3'h3: v[3] = req;
      3'h4: v[4] = req;
      3'h5: v[5] = req;
      3'h6: v[6] = req;
      3'h7: v[7] = req;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Access decode shared by the guard, the config register and the steering path
  always_comb begin
    hit = is_cfg_slot(page_sel, acc.addr);
    commit = acc.wr && hit && (state_q == ICRA_ARMED);
    steer = acc.wr && hit && (state_q != ICRA_ARMED);
  end

  // Guard: a read of the slot arms it, the next access of any kind spends it, except another slot read, which keeps it armed
  // Idle cycles leave it alone, so a host may pause between the read and the write
  always_comb begin
    state_d = state_q;
    if (acc.rd) begin
      state_d = hit ? ICRA_ARMED : ICRA_IDLE;
    end else if (acc.wr) begin
      state_d = ICRA_IDLE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ICRA_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Only a committing write changes the config; it resets to all zeros
  always_comb begin
    cfg_d = cfg_q;
    if (commit) begin
      cfg_d = icra_config_s'(acc.wdata);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= icra_config_s'(ICRA_CONFIG_RESET);
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Read data holds between reads, so a slow host can still pick it up
  always_comb begin
    rdata_d = rdata;
    if (acc.rd && hit) begin
      rdata_d = cfg_q;
    end else if (acc.rd) begin
      rdata_d = core_rdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_d;
    end
  end

  always_comb begin
    rd_hit_d = acc.rd && hit;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rd_hit <= 1'b0;
    end else begin
      cfg_rd_hit <= rd_hit_d;
    end
  end

  always_comb begin
    rbcl_we_d = steer;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remote_byte_count_low_we <= 1'b0;
    end else begin
      remote_byte_count_low_we <= rbcl_we_d;
    end
  end

  // The byte count low byte is kept here only as the target of unguarded writes
  always_comb begin
    rbcl_d = remote_byte_count_low;
    if (steer) begin
      rbcl_d = acc.wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remote_byte_count_low <= 8'h00;
    end else begin
      remote_byte_count_low <= rbcl_d;
    end
  end

  // Pins derived from the config lag it by one cycle so each one leaves a flop
  always_comb begin
    io_base_d = io_base_of(cfg_q.io_base_sel);
  end

  // Reset value is the base that the all-zero config selects
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_base <= ICRA_IOBASE_HI;
    end else begin
      io_base <= io_base_d;
    end
  end

  always_comb begin
    irq_d = irq_decode(cfg_q.irq_sel, irq_req);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_lines <= 8'h00;
    end else begin
      irq_lines <= irq_d;
    end
  end

  always_comb begin
    fast_d = cfg_q.fast_remote_read;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_remote_read <= 1'b0;
    end else begin
      fast_remote_read <= fast_d;
    end
  end

  always_comb begin
    page2_d = (page_sel == ICRA_PAGE_2);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page2_sel <= 1'b0;
    end else begin
      page2_sel <= page2_d;
    end
  end

endmodule

// *** icra_config_reg_bench.sv ***
// Bench: table of config values, then steering, page and reset cases
`timescale 1ns/1ps
module icra_config_reg_bench;
  import icra_pkg::*;
  logic clk = 0, arst_n = 0, irq_req = 1, page2_sel, cfg_rd_hit, remote_byte_count_low_we, fast_remote_read;
  logic [1:0] page_sel = 0;
  logic [7:0] core_rdata = 8'h5a, rdata, remote_byte_count_low, irq_lines;
  logic [9:0] io_base;
  icra_access_s acc;
  int fails = 0, tests_run = 0;
  // Row: written value, then {fast, irq lines, io base}
  logic [26:0] row [8] = '{27'h700, 27'hc80a20, 27'h5141340, 27'h1d82260, 27'h6244380, 27'h2e882a0,
    27'h73503c0, 27'h3fa02e0};
  always #10 clk = ~clk;
  icra_host icra_host_i(.clk(clk), .acc(acc));
  icra_config_reg icra_config_reg_i(
    .clk(clk),
    .arst_n(arst_n),
    .acc(acc),
    .page_sel(page_sel),
    .core_rdata(core_rdata),
    .irq_req(irq_req),
    .rdata(rdata),
    .cfg_rd_hit(cfg_rd_hit),
    .remote_byte_count_low_we(remote_byte_count_low_we),
    .remote_byte_count_low(remote_byte_count_low),
    .io_base(io_base),
    .irq_lines(irq_lines),
    .fast_remote_read(fast_remote_read),
    .page2_sel(page2_sel)
  );
  task chk(input logic [18:0] s, e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("Error %0t %h %h", $time, s, e);
    end
  endtask
  task report_and_stop;
    $display("%0d run %0d fails", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #50000 fails++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clk);
    #2 arst_n = 1;
    chk({irq_lines, io_base}, 19'h300);
    foreach (row[i]) begin
      icra_host_i.op(1, ICRA_OFS_CONFIG, 0);
      icra_host_i.op(0, ICRA_OFS_CONFIG, row[i][26:19]);
      #40 chk({fast_remote_read, irq_lines, io_base}, row[i][18:0]);
      icra_host_i.op(1, ICRA_OFS_CONFIG, 0);
      chk({cfg_rd_hit, rdata}, {1'b1, row[i][26:19]});
    end
    // Another access in between must cancel the guard
    icra_host_i.op(1, 4'h9, 0);
    chk({cfg_rd_hit, rdata}, 9'h05a);
    icra_host_i.op(0, ICRA_OFS_CONFIG, 8'h33);
    chk({remote_byte_count_low_we, remote_byte_count_low}, 9'h133);
    // A write in between spends the guard, and so does a steered write itself
    icra_host_i.op(1, ICRA_OFS_CONFIG, 0);
    icra_host_i.op(0, 4'h5, 8'h11);
    icra_host_i.op(0, ICRA_OFS_CONFIG, 8'h44);
    chk({remote_byte_count_low_we, remote_byte_count_low}, 9'h144);
    icra_host_i.op(0, ICRA_OFS_CONFIG, 8'h55);
    chk({remote_byte_count_low_we, remote_byte_count_low}, 9'h155);
    #40 chk({fast_remote_read, irq_lines, io_base}, 19'h202e0);
    page_sel = ICRA_PAGE_2;
    irq_req = 0;
    #40 chk({page2_sel, irq_lines, io_base}, 19'h402e0);
    // Offset 0AH of page 2 is another register: no config read, no steering
    icra_host_i.op(1, ICRA_OFS_CONFIG, 0);
    chk({cfg_rd_hit, rdata}, 9'h05a);
    icra_host_i.op(0, ICRA_OFS_CONFIG, 8'h66);
    chk({remote_byte_count_low_we, remote_byte_count_low}, 9'h055);
    page_sel = 2'h3;
    #40 chk(page2_sel, 19'h0);
    page_sel = 2'h1;
    #40 chk(page2_sel, 19'h0);
    // Reset in mid-run: config and guard both return to idle
    page_sel = ICRA_PAGE_0;
    arst_n = 0;
    repeat (2) @(posedge clk);
    #2 arst_n = 1;
    chk({fast_remote_read, irq_lines, io_base}, 19'h300);
    icra_host_i.op(0, ICRA_OFS_CONFIG, 8'h77);
    chk({remote_byte_count_low_we, remote_byte_count_low}, 9'h177);
    icra_host_i.op(1, ICRA_OFS_CONFIG, 0);
    chk({cfg_rd_hit, rdata}, 9'h100);
    report_and_stop;
  end
endmodule

// *** icra_host.sv ***
// Host model: one register access per call, strobe held over the taking edge
`timescale 1ns/1ps
module icra_host
  import icra_pkg::*;
(
  input wire logic clk,
  output icra_access_s acc = '0
);
  task op(input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) #2 acc = {r, !r, a, d};
    @(posedge clk) #2 acc = '0;
  endtask
endmodule

// *** icra_pkg.sv ***
// Package for the ISA resource configuration register block.
// Assumes one 50 MHz clock and an 8-bit register access port with 4-bit offset.
package icra_pkg;

  localparam logic [3:0] ICRA_OFS_CONFIG = 4'ha;
  localparam logic [1:0] ICRA_PAGE_0 = 2'h0;
  localparam logic [1:0] ICRA_PAGE_2 = 2'h2;
  localparam logic [7:0] ICRA_CONFIG_RESET = 8'h00;
  localparam int ICRA_IOSEL_LSB = 0;
  localparam int ICRA_IRQSEL_LSB = 4;
  localparam int ICRA_FAST_BIT = 7;
  localparam logic [9:0] ICRA_IOBASE_HI = 10'h300;
  localparam logic [9:0] ICRA_IOBASE_LO = 10'h200;
  localparam int ICRA_IOBASE_STEP_LSB = 5;

  typedef struct packed {
    logic fast_remote_read;
    logic [2:0] irq_sel;
    logic [3:0] io_base_sel;
  } icra_config_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } icra_access_s;

  typedef enum logic [0:0] {
    ICRA_IDLE = 1'b0,
    ICRA_ARMED = 1'b1
  } icra_state_e;

endpackage

// *** icra_properties.sv ***
// Checker bound to the config register block; one clock domain
`timescale 1ns/1ps
module icra_props
  import icra_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic irq_req,
  input wire logic page2_sel,
  input wire logic cfg_rd_hit,
  input wire logic remote_byte_count_low_we,
  input wire logic fast_remote_read,
  input wire logic [1:0] page_sel,
  input wire logic [7:0] irq_lines,
  input wire logic [9:0] io_base,
  input wire icra_access_s acc
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire c = acc.addr == ICRA_OFS_CONFIG && page_sel == ICRA_PAGE_0;
  wire n = !acc.rd && !acc.wr;
  sequence s_ok; acc.rd && c ##1 n ##1 acc.wr && c; endsequence
  sequence s_bad; acc.rd && !c ##1 n ##1 acc.wr && c; endsequence
  sequence s_twice; acc.wr && c ##1 n ##1 acc.wr && c; endsequence
  a_page_flag: assert property (page_sel == ICRA_PAGE_2 |=> page2_sel) else $error("page");
  a_page_low: assert property (page_sel != ICRA_PAGE_2 |=> !page2_sel) else $error("page");
  a_commit_kept: assert property (s_ok |=> !remote_byte_count_low_we) else $error("commit");
  a_steer_write: assert property (s_bad |=> remote_byte_count_low_we) else $error("steer");
  a_base_map: assert property (s_ok |=> ##1 io_base ==
    {1'b1, ~$past(acc.wdata[3], 2), $past(acc.wdata[2:0], 2), 5'h00}) else $error("base");
  a_irq_one: assert property (irq_req |=> $onehot(irq_lines)) else $error("irq");
  a_irq_idle: assert property (!irq_req |=> !irq_lines) else $error("idle");
  a_fast_bit: assert property (s_ok |=> ##1 fast_remote_read == $past(acc.wdata[7], 2)) else $error("fast");
  a_irq_map: assert property (s_ok ##1 irq_req |=> irq_lines == (8'h01 << $past(acc.wdata[6:4], 2)))
    else $error("irq map");
  a_read_hit: assert property (acc.rd && c |=> cfg_rd_hit) else $error("read hit");
  a_bare_write: assert property (s_twice |=> remote_byte_count_low_we) else $error("bare write");
endmodule
bind icra_config_reg icra_props icra_props_i(
  .clk(clk),
  .arst_n(arst_n),
  .irq_req(irq_req),
  .page2_sel(page2_sel),
  .cfg_rd_hit(cfg_rd_hit),
  .remote_byte_count_low_we(remote_byte_count_low_we),
  .fast_remote_read(fast_remote_read),
  .page_sel(page_sel),
  .irq_lines(irq_lines),
  .io_base(io_base),
  .acc(acc)
);
